// ===== include/dpsm_pkg.sv
// package: register map, field positions and state encodings of the drive power state machine
package dpsm_pkg;
   // register offsets (object indices)
   localparam logic [15:0] ADDR_CMD_WORD = 16'h6040;
   localparam logic [15:0] ADDR_STATE_WORD = 16'h6041;
   localparam logic [15:0] ADDR_MODE_REQ = 16'h6060;
   localparam logic [15:0] ADDR_MODE_ACT = 16'h6061;
   localparam logic [15:0] ADDR_HOLD_OPT = 16'h3212;
   localparam logic [15:0] ADDR_IRQ_STAT = 16'h7000;
   localparam logic [15:0] ADDR_IRQ_MASK = 16'h7001;
   // command word bit positions
   localparam int CW_SO = 0;
   localparam int CW_EV = 1;
   localparam int CW_QS = 2;
   localparam int CW_EO = 3;
   localparam int CW_FR = 7;
   // state word bit positions
   localparam int SW_QS = 5;
   localparam int SW_SOD = 6;
   localparam int SW_IDX = 15;
   // interrupt status bits
   localparam int IRQ_STATE_CHG = 0;
   localparam int IRQ_FAULT = 1;
   localparam int IRQ_BUS_ERR = 2;
   localparam int IRQ_UNRECOV = 3;
   localparam int IRQ_W = 4;
   // reset values
   localparam logic [15:0] RST_CMD_WORD = 16'h0000;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic RST_HOLD_OPT = 1'b0;
   localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;

   typedef enum logic [3:0] {
      ST_NOT_READY,
      ST_SW_ON_DIS,
      ST_READY,
      ST_SWITCHED_ON,
      ST_OP_ENABLED,
      ST_QUICK_STOP,
      ST_FAULT_REACT,
      ST_FAULT
   } dpsm_state_t;

   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_SHUTDOWN,
      CMD_SWITCH_ON,
      CMD_DIS_VOLT,
      CMD_QUICK_STOP,
      CMD_ENABLE_OP
   } dpsm_cmd_t;
endpackage : dpsm_pkg

// ===== src/dpsm_sync.sv
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`default_nettype none
module dpsm_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_async,
   output var logic o_level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } dpsm_sync_t;
   dpsm_sync_t r_q, r_d;

   always_comb begin
      r_d = r_q;
      r_d.s1 = i_async;
      r_d.s2 = r_q.s1;
      r_d.s3 = r_q.s2;
      if (r_q.s2 == r_q.s3) begin
         r_d.lvl = r_q.s3;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         r_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL};
      end else begin
         r_q <= r_d;
      end
   end

   assign o_level = r_q.lvl;
endmodule : dpsm_sync
`default_nettype wire

// ===== src/dpsm_top.sv
// drive power state machine: command decode, state word, mode gating, interrupts
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE_01: state changes come only via command word; state shown only in read-only state word.
// RULE_02: bits 7,3,2,1,0 decode shutdown, switch on, disable and enable operation.
// RULE_03: don't-care bits ignored; disable voltage and quick stop decoded from bits 7,2,1.
// RULE_04: fault reset only on rising edge of command bit 7; held level ignored.
// RULE_05: state word bits 6,5,3..0 encode each of the eight states.
// RULE_06: after reset and self-test pass, enter switch on disabled unprompted.
// RULE_07: requested mode takes effect only in operation enabled; active mode shown separately.
// RULE_08: mode writes accepted only in switch on disabled, ready, switched on.
// RULE_09: unrecoverable error forces not ready permanently; commands then ignored.
// RULE_10: bus error forces not ready; on clearing, return to switch on disabled.
// RULE_11: holding torque in switched on only when holding option written with one.
// RULE_12: state word bit 15 set once encoder index seen, when encoder commutates.
// RULE_13: invalid command for current state leaves state and state word unchanged.
module dpsm_top
   import dpsm_pkg::*;
(
   input wire logic I_CLK_SYS,
   input wire logic I_RSTN,
   input wire logic [15:0] I_ADDR,
   input wire logic [15:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [15:0] O_RDATA,
   input wire logic I_SELFTEST_OK,
   input wire logic I_FAULT,
   input wire logic I_FAULT_REACT_DONE,
   input wire logic I_UNRECOV_ERR,
   input wire logic I_BUS_ERR,
   input wire logic I_ENC_COMMUT,
   input wire logic I_ENC_INDEX,
   output logic O_POWER_EN,
   output logic O_HOLD_TORQUE,
   output logic O_QUICK_STOP,
   output logic [7:0] O_MODE_ACT,
   output logic O_IRQ
);
   typedef struct packed {
      dpsm_state_t st;
      logic [15:0] cw;
      logic fr_prev;
      logic [7:0] mode_req;
      logic [7:0] mode_act;
      logic hold_opt;
      logic idx_seen;
      logic unrecov;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic [15:0] rdata;
   } dpsm_regs_t;
   dpsm_regs_t r_q, r_d;

   logic st_ok, flt, flt_done, unrec, bus_err, enc_com, enc_idx;
   dpsm_cmd_t cmd;
   logic [15:0] cw_new, sw;
   logic fr_edge, cw_wr;
   logic [IRQ_W-1:0] ev;

   // pin inputs from outside the clock domain
   dpsm_sync u_s_ok (.i_clk(I_CLK_SYS), .i_rstn(I_RSTN), .i_async(I_SELFTEST_OK), .o_level(st_ok));
   dpsm_sync u_s_flt (.i_clk(I_CLK_SYS), .i_rstn(I_RSTN), .i_async(I_FAULT), .o_level(flt));
   dpsm_sync u_s_fd (.i_clk(I_CLK_SYS), .i_rstn(I_RSTN), .i_async(I_FAULT_REACT_DONE), .o_level(flt_done));
   dpsm_sync u_s_ur (.i_clk(I_CLK_SYS), .i_rstn(I_RSTN), .i_async(I_UNRECOV_ERR), .o_level(unrec));
   dpsm_sync u_s_be (.i_clk(I_CLK_SYS), .i_rstn(I_RSTN), .i_async(I_BUS_ERR), .o_level(bus_err));
   dpsm_sync u_s_ec (.i_clk(I_CLK_SYS), .i_rstn(I_RSTN), .i_async(I_ENC_COMMUT), .o_level(enc_com));
   dpsm_sync u_s_ix (.i_clk(I_CLK_SYS), .i_rstn(I_RSTN), .i_async(I_ENC_INDEX), .o_level(enc_idx));

   assign cw_wr = I_WR && (I_ADDR == ADDR_CMD_WORD);
   assign cw_new = cw_wr ? I_WDATA : r_q.cw; // see RULE_01

   // command decode from the freshly written word
   always_comb begin
      cmd = CMD_NONE;
      if (cw_wr && !cw_new[CW_FR]) begin
         if (!cw_new[CW_EV]) begin
            cmd = CMD_DIS_VOLT; // see RULE_03
         end else if (!cw_new[CW_QS]) begin
            cmd = CMD_QUICK_STOP; // see RULE_03
         end else if (!cw_new[CW_SO]) begin
            cmd = CMD_SHUTDOWN; // see RULE_02
         end else if (!cw_new[CW_EO]) begin
            cmd = CMD_SWITCH_ON; // see RULE_02
         end else begin
            cmd = CMD_ENABLE_OP; // see RULE_02
         end
      end
   end

   assign fr_edge = cw_wr && cw_new[CW_FR] && !r_q.fr_prev; // see RULE_04

   // state word encoding
   always_comb begin
      sw = 16'h0000;
      case (r_q.st)
         ST_NOT_READY: sw[6:0] = 7'h00; // see RULE_05
         ST_SW_ON_DIS: sw[6:0] = 7'h40;
         ST_READY: sw[6:0] = 7'h21;
         ST_SWITCHED_ON: sw[6:0] = 7'h23;
         ST_OP_ENABLED: sw[6:0] = 7'h27;
         ST_QUICK_STOP: sw[6:0] = 7'h07;
         ST_FAULT_REACT: sw[6:0] = 7'h0F;
         ST_FAULT: sw[6:0] = 7'h08;
         default: sw[6:0] = 7'h00;
      endcase
      sw[SW_IDX] = enc_com && r_q.idx_seen; // see RULE_12
   end

   always_comb begin
      r_d = r_q;
      ev = '0;
      r_d.cw = cw_new;
      if (cw_wr) begin
         r_d.fr_prev = cw_new[CW_FR];
      end
      if (enc_idx) begin
         r_d.idx_seen = 1'b1;
      end
      if (unrec) begin
         r_d.unrecov = 1'b1;
      end
      // transitions
      if (r_q.unrecov || unrec) begin
         r_d.st = ST_NOT_READY; // see RULE_09
      end else if (bus_err) begin
         r_d.st = ST_NOT_READY; // see RULE_10
      end else if (flt && r_q.st != ST_FAULT && r_q.st != ST_FAULT_REACT && r_q.st != ST_NOT_READY) begin
         r_d.st = ST_FAULT_REACT;
      end else begin
         case (r_q.st)
            ST_NOT_READY: begin
               if (st_ok) begin
                  r_d.st = ST_SW_ON_DIS; // see RULE_06
               end
            end
            ST_SW_ON_DIS: begin
               if (cmd == CMD_SHUTDOWN) begin
                  r_d.st = ST_READY;
               end
            end
            ST_READY: begin
               if (cmd == CMD_SWITCH_ON) begin
                  r_d.st = ST_SWITCHED_ON;
               end else if (cmd == CMD_DIS_VOLT) begin
                  r_d.st = ST_SW_ON_DIS;
               end
            end
            ST_SWITCHED_ON: begin
               if (cmd == CMD_ENABLE_OP) begin
                  r_d.st = ST_OP_ENABLED;
               end else if (cmd == CMD_SHUTDOWN) begin
                  r_d.st = ST_READY;
               end else if (cmd == CMD_DIS_VOLT) begin
                  r_d.st = ST_SW_ON_DIS;
               end
            end
            ST_OP_ENABLED: begin
               if (cmd == CMD_SWITCH_ON) begin
                  r_d.st = ST_SWITCHED_ON; // see RULE_02
               end else if (cmd == CMD_SHUTDOWN) begin
                  r_d.st = ST_READY;
               end else if (cmd == CMD_DIS_VOLT) begin
                  r_d.st = ST_SW_ON_DIS;
               end else if (cmd == CMD_QUICK_STOP) begin
                  r_d.st = ST_QUICK_STOP;
               end
            end
            ST_QUICK_STOP: begin
               if (cmd == CMD_DIS_VOLT) begin
                  r_d.st = ST_SW_ON_DIS;
               end
            end
            ST_FAULT_REACT: begin
               if (flt_done) begin
                  r_d.st = ST_FAULT;
               end
            end
            ST_FAULT: begin
               if (fr_edge) begin
                  r_d.st = ST_SW_ON_DIS; // see RULE_04
               end
            end
            default: r_d.st = ST_NOT_READY;
         endcase
         // other commands fall through unchanged, see RULE_13
      end
      // mode gating
      if (I_WR && I_ADDR == ADDR_MODE_REQ && (r_q.st == ST_SW_ON_DIS || r_q.st == ST_READY
            || r_q.st == ST_SWITCHED_ON)) begin
         r_d.mode_req = I_WDATA[7:0]; // see RULE_08
      end
      if (r_q.st == ST_OP_ENABLED) begin
         r_d.mode_act = r_q.mode_req; // see RULE_07
      end
      if (I_WR && I_ADDR == ADDR_HOLD_OPT) begin
         r_d.hold_opt = I_WDATA[0];
      end
      if (I_WR && I_ADDR == ADDR_IRQ_MASK) begin
         r_d.irq_mask = I_WDATA[IRQ_W-1:0];
      end
      // events; set wins over write-one clear
      ev[IRQ_STATE_CHG] = r_d.st != r_q.st;
      ev[IRQ_FAULT] = r_d.st == ST_FAULT_REACT && r_q.st != ST_FAULT_REACT;
      ev[IRQ_BUS_ERR] = bus_err && r_q.st != ST_NOT_READY;
      ev[IRQ_UNRECOV] = unrec && !r_q.unrecov;
      if (I_WR && I_ADDR == ADDR_IRQ_STAT) begin
         r_d.irq_stat = r_q.irq_stat & ~I_WDATA[IRQ_W-1:0];
      end
      r_d.irq_stat = r_d.irq_stat | ev;
      // read port, data one cycle later
      r_d.rdata = 16'h0000;
      if (I_RD) begin
         case (I_ADDR)
            ADDR_CMD_WORD: r_d.rdata = r_q.cw;
            ADDR_STATE_WORD: r_d.rdata = sw; // see RULE_01
            ADDR_MODE_REQ: r_d.rdata = {8'h00, r_q.mode_req};
            ADDR_MODE_ACT: r_d.rdata = {8'h00, r_q.mode_act}; // see RULE_07
            ADDR_HOLD_OPT: r_d.rdata = {15'h0000, r_q.hold_opt};
            ADDR_IRQ_STAT: r_d.rdata = {12'h000, r_q.irq_stat};
            ADDR_IRQ_MASK: r_d.rdata = {12'h000, r_q.irq_mask};
            default: r_d.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
         r_q.st <= ST_NOT_READY;
         r_q.cw <= RST_CMD_WORD;
         r_q.fr_prev <= 1'b0;
         r_q.mode_req <= RST_MODE;
         r_q.mode_act <= RST_MODE;
         r_q.hold_opt <= RST_HOLD_OPT;
         r_q.idx_seen <= 1'b0;
         r_q.unrecov <= 1'b0;
         r_q.irq_stat <= '0;
         r_q.irq_mask <= RST_IRQ_MASK;
         r_q.rdata <= 16'h0000;
      end else begin
         r_q <= r_d;
      end
   end

   assign O_RDATA = r_q.rdata;
   assign O_POWER_EN = r_q.st == ST_OP_ENABLED || r_q.st == ST_QUICK_STOP
      || (r_q.st == ST_SWITCHED_ON && r_q.hold_opt);
   assign O_HOLD_TORQUE = r_q.st == ST_SWITCHED_ON && r_q.hold_opt; // see RULE_11
   assign O_QUICK_STOP = r_q.st == ST_QUICK_STOP;
   assign O_MODE_ACT = r_q.mode_act;
   assign O_IRQ = |(r_q.irq_stat & r_q.irq_mask);

   a_unrecov_stay: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      r_q.unrecov |=> r_q.st == ST_NOT_READY) else $error("left not ready after unrecoverable error"); // see RULE_09
   a_bus_err_force: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      bus_err |=> r_q.st == ST_NOT_READY) else $error("bus error did not force not ready"); // see RULE_10
   a_bus_clr_return: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      (r_q.st == ST_NOT_READY && !bus_err && st_ok && !r_q.unrecov && !unrec) |=> r_q.st == ST_SW_ON_DIS)
      else $error("no return to switch on disabled"); // see RULE_06
   a_fr_edge_only: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      (r_q.st == ST_FAULT && !fr_edge && !bus_err && !r_q.unrecov && !unrec) |=> r_q.st == ST_FAULT)
      else $error("fault left without rising edge"); // see RULE_04
   a_fault_exit: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      (r_q.st == ST_FAULT && fr_edge && !bus_err && !r_q.unrecov && !unrec) |=> r_q.st == ST_SW_ON_DIS)
      else $error("fault reset edge ignored"); // see RULE_04
   a_mode_locked: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      (r_q.st == ST_OP_ENABLED || r_q.st == ST_FAULT) |=> $stable(r_q.mode_req))
      else $error("mode changed outside allowed states"); // see RULE_08
   a_mode_active: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      (r_q.st != ST_OP_ENABLED) |=> $stable(O_MODE_ACT)) else $error("mode took effect early"); // see RULE_07
   a_enable_op: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      (r_q.st == ST_SWITCHED_ON && cmd == CMD_ENABLE_OP && !flt && !bus_err && !r_q.unrecov && !unrec)
      |=> r_q.st == ST_OP_ENABLED) else $error("enable operation lost"); // see RULE_02
   a_hold_torque: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      O_HOLD_TORQUE |-> (r_q.hold_opt && sw[6:0] == 7'h23)) else $error("holding torque without option"); // see RULE_11
   a_qs_code: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      (r_q.st == ST_QUICK_STOP) |-> sw[SW_SOD:0] == 7'h07 && !sw[SW_QS]) else $error("quick stop code wrong"); // see RULE_05
   a_idx_bit: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      sw[SW_IDX] |-> r_q.idx_seen) else $error("index bit without index"); // see RULE_12
   a_invalid_cmd: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      (r_q.st == ST_SW_ON_DIS && cmd == CMD_ENABLE_OP && !flt && !bus_err && !r_q.unrecov && !unrec)
      |=> r_q.st == ST_SW_ON_DIS) else $error("invalid command moved state"); // see RULE_13
endmodule : dpsm_top
`default_nettype wire

// ===== bench/dpsm_master.sv
// fieldbus master model: issues register writes and reads on the plain port
`timescale 1ns/1ps
`default_nettype none
module dpsm_master (
   input wire logic i_clk,
   output logic [15:0] o_addr,
   output logic [15:0] o_wdata,
   output logic o_wr,
   output logic o_rd
);
   initial begin
      o_addr = 16'h0000;
      o_wdata = 16'h0000;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end

   // one-cycle write; state changes go only through the command word
   task automatic wr_req(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask : wr_req

   task automatic rd_req(input logic [15:0] a);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
   endtask : rd_req
endmodule : dpsm_master
`default_nettype wire

// ===== bench/drive_power_state_machine_bench.sv
// self-checking bench of the drive power state machine
`timescale 1ns/1ps
`default_nettype none
module drive_power_state_machine_bench;
   import dpsm_pkg::*;
   logic clk = 1'b0;
   logic rstn, st_ok, flt, flt_done, unrec, bus_err, commut, idx;
   logic [15:0] addr, wdata, rdata;
   logic bus_wr, rd, pwr, hold, qs, irq, rd_seen;
   logic [7:0] mode_act, lfsr, mode;
   logic [15:0] exp_q[$];
   logic [15:0] cmds[7] = '{16'h000E, 16'h0007, 16'h000F, 16'h0007, 16'h000F, 16'h000B, 16'h0075};
   logic [15:0] sws[7] = '{16'h0021, 16'h0023, 16'h0027, 16'h0023, 16'h0027, 16'h0007, 16'h0040};
   int n_errors = 0;
   int n_compared = 0;

   always #20 clk = ~clk;

   dpsm_master u_dpsm_master (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(bus_wr), .o_rd(rd));

   dpsm_top u_dpsm_top (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(bus_wr),
      .I_RD(rd), .O_RDATA(rdata), .I_SELFTEST_OK(st_ok), .I_FAULT(flt), .I_FAULT_REACT_DONE(flt_done),
      .I_UNRECOV_ERR(unrec), .I_BUS_ERR(bus_err), .I_ENC_COMMUT(commut), .I_ENC_INDEX(idx),
      .O_POWER_EN(pwr), .O_HOLD_TORQUE(hold), .O_QUICK_STOP(qs), .O_MODE_ACT(mode_act), .O_IRQ(irq));

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next

   task automatic end_sim();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim

   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t word got %h expected %h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t level got %b expected %b", $time, got, exp);
      end
   endtask : cmp_bit

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic rd_exp(input logic [15:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      u_dpsm_master.rd_req(a);
   endtask : rd_exp

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      u_dpsm_master.wr_req(a, d);
   endtask : wr

   // read data stand only in the cycle after the strobe
   always @(posedge clk) begin
      rd_seen <= rd;
   end

   always @(negedge clk) begin
      if (rd_seen === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("[ERR] %0t read data without a pending read", $time);
         end else begin
            cmp_word(rdata, exp_q.pop_front());
         end
      end
   end

   initial begin
      cyc(5000);
      n_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      end_sim();
   end

   initial begin
      rstn = 1'b0;
      st_ok = 1'b1;
      {flt, flt_done, unrec, bus_err, commut, idx} = 6'h00;
      lfsr = 8'h19;
      cyc(12);
      rstn <= 1'b1;
      cyc(8);
      rd_exp(ADDR_STATE_WORD, 16'h0040);
      rd_exp(ADDR_IRQ_MASK, 16'h0000);
      rd_exp(16'h1234, 16'h0000);
      wr(ADDR_STATE_WORD, 16'h0027);
      wr(ADDR_CMD_WORD, 16'h000F);
      rd_exp(ADDR_STATE_WORD, 16'h0040);
      lfsr = lfsr_next(lfsr);
      mode = lfsr;
      wr(ADDR_MODE_REQ, {8'h00, mode});
      for (int i = 0; i < 7; i++) begin
         wr(ADDR_CMD_WORD, cmds[i]);
         rd_exp(ADDR_STATE_WORD, sws[i]);
         if (i == 1) begin
            cmp_bit(hold, 1'b0);
         end
         if (i == 2) begin
            cmp_bit(pwr, 1'b1);
            cmp_word({8'h00, mode_act}, {8'h00, mode});
            lfsr = lfsr_next(lfsr);
            wr(ADDR_MODE_REQ, {8'h00, lfsr});
            rd_exp(ADDR_MODE_REQ, {8'h00, mode});
            rd_exp(ADDR_MODE_ACT, {8'h00, mode});
         end
         if (i == 5) begin
            cmp_bit(qs, 1'b1);
         end
      end
      wr(ADDR_HOLD_OPT, 16'h0001);
      wr(ADDR_CMD_WORD, 16'h0006);
      wr(ADDR_CMD_WORD, 16'h0007);
      // outputs settle on the edge that takes the write strobe; check one edge later
      cyc(1);
      cmp_bit(hold, 1'b1);
      cmp_bit(pwr, 1'b1);
      wr(ADDR_CMD_WORD, 16'h0000);
      wr(ADDR_IRQ_MASK, 16'h0002);
      for (int k = 0; k < 2; k++) begin
         flt <= 1'b1;
         cyc(8);
         rd_exp(ADDR_STATE_WORD, 16'h000F);
         flt_done <= 1'b1;
         cyc(8);
         rd_exp(ADDR_STATE_WORD, 16'h0008);
         cmp_bit(irq, 1'b1);
         flt <= 1'b0;
         flt_done <= 1'b0;
         wr(ADDR_IRQ_STAT, 16'h000F);
         cyc(1);
         cmp_bit(irq, 1'b0);
         if (k == 1) begin
            wr(ADDR_CMD_WORD, 16'h0080);
            rd_exp(ADDR_STATE_WORD, 16'h0008);
            wr(ADDR_CMD_WORD, 16'h0000);
            rd_exp(ADDR_STATE_WORD, 16'h0008);
         end
         wr(ADDR_CMD_WORD, 16'h0080);
         rd_exp(ADDR_STATE_WORD, 16'h0040);
      end
      bus_err <= 1'b1;
      cyc(8);
      rd_exp(ADDR_STATE_WORD, 16'h0000);
      bus_err <= 1'b0;
      cyc(8);
      rd_exp(ADDR_STATE_WORD, 16'h0040);
      commut <= 1'b1;
      cyc(8);
      rd_exp(ADDR_STATE_WORD, 16'h0040);
      idx <= 1'b1;
      cyc(4);
      idx <= 1'b0;
      cyc(8);
      rd_exp(ADDR_STATE_WORD, 16'h8040);
      unrec <= 1'b1;
      cyc(8);
      rd_exp(ADDR_STATE_WORD, 16'h8000);
      unrec <= 1'b0;
      wr(ADDR_CMD_WORD, 16'h0006);
      cyc(8);
      rd_exp(ADDR_STATE_WORD, 16'h8000);
      // state change, bus error and unrecoverable events since the last clear
      rd_exp(ADDR_IRQ_STAT, 16'h000D);
      cyc(4);
      end_sim();
   end
endmodule : drive_power_state_machine_bench
`default_nettype wire
